// >>> rtl/spi_cfg_pkg.sv
package spi_cfg_pkg;
  localparam int unsigned DW            = 8;
  localparam int unsigned AW            = 6;
  localparam int unsigned STATE_W       = 3;
  localparam int unsigned HDR_RW_BIT    = 7;
  localparam int unsigned HDR_BURST_BIT = 6;
  localparam logic [5:0]  CFG_LAST      = 6'h2E;
  localparam int unsigned CFG_NUM       = 47;
  localparam logic [5:0]  STAT_FIRST    = 6'h30;
  localparam logic [5:0]  STAT_LAST     = 6'h3D;
  localparam logic [5:0]  BUF_ADDR      = 6'h3F;
  localparam logic [7:0]  CFG_RST       = 8'h00;
  localparam logic [3:0]  AVAIL_MAX     = 4'hF;
  localparam int unsigned BUF_DEPTH     = 64;
  localparam int unsigned BUF_CW        = 7;
  localparam int unsigned HQ_DEPTH      = 16;
  localparam int unsigned HQ_CW         = 5;
  // Host register port
  localparam int unsigned RA_W          = 4;
  localparam int unsigned RD_W          = 16;
  localparam logic [3:0]  REG_CMD       = 4'h0;
  localparam logic [3:0]  REG_STAT      = 4'h1;
  localparam logic [3:0]  REG_TXD       = 4'h2;
  localparam logic [3:0]  REG_RXD       = 4'h3;
  localparam int unsigned CMD_HDR_LSB   = 0;
  localparam int unsigned CMD_LEN_LSB   = 8;
  localparam int unsigned STAT_RXC_LSB  = 0;
  localparam int unsigned STAT_TXC_LSB  = 5;
  localparam int unsigned STAT_BUSY_BIT = 10;
  // Host link timing
  localparam int unsigned CNT_W         = 4;
  localparam int unsigned CLK_NS        = 10;
  localparam int unsigned SCLK_HALF_NS  = 80;
  localparam int unsigned CS_GAP_NS     = 120;
  localparam logic [3:0]  SCLK_HALF_CYC =
    4'((SCLK_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  CS_GAP_CYC    =
    4'((CS_GAP_NS + CLK_NS - 1) / CLK_NS);
endpackage

// >>> rtl/spi_link_if.sv
`timescale 1ns/10ps
interface spi_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  modport dev  (input cs_n, input sclk, input mosi, output miso);
  modport host (output cs_n, output sclk, output mosi, input miso);
endinterface

// >>> rtl/sync_fifo.sv
`timescale 1ns/10ps
module sync_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned PW    = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          rst_i,
  // Fill side
  input  wire logic          in_valid_i,
  output logic               in_ready_o,
  input  wire logic [W-1:0]  in_data_i,
  // Drain side
  output logic               out_valid_o,
  input  wire logic          out_ready_i,
  output logic [W-1:0]       out_data_o,
  output logic [PW:0]        count_o
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [PW:0]             cnt;
    logic                    rdy;
    logic                    vld;
  } fifo_s;

  fifo_s q;
  fifo_s d;
  logic  push;
  logic  pop;

  always_comb begin
    d = q;
    push = in_valid_i && (q.cnt != (PW+1)'(DEPTH));
    pop = out_ready_i && (q.cnt != '0);
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    case ({push, pop})
      2'b10:   d.cnt = q.cnt + 1'b1;
      2'b01:   d.cnt = q.cnt - 1'b1;
      default: d.cnt = q.cnt;
    endcase
    // Flags kept in flops so the ports come from registers
    d.rdy = d.cnt != (PW+1)'(DEPTH);
    d.vld = d.cnt != '0;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign in_ready_o  = q.rdy;
  assign out_valid_o = q.vld;
  assign out_data_o  = q.mem[q.rp];
  assign count_o     = q.cnt;
endmodule

// >>> rtl/radio_spi_dev.sv
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module radio_spi_dev (
  // Clock and reset
  input  wire logic                           ref_clk_i,
  input  wire logic                           rst_i,
  // Serial link
  spi_link_if.dev                             link,
  // Radio core status
  input  wire logic                           xosc_run_i,
  input  wire logic [spi_cfg_pkg::STATE_W-1:0] main_state_i,
  // Configuration writes
  output logic                                cfg_wr_o,
  output logic [spi_cfg_pkg::AW-1:0]          cfg_addr_o,
  output logic [spi_cfg_pkg::DW-1:0]          cfg_data_o,
  // Command strobes
  output logic                                strobe_o,
  output logic [spi_cfg_pkg::AW-1:0]          strobe_addr_o,
  // Transmit buffer drain
  output logic [spi_cfg_pkg::DW-1:0]          tx_data_o,
  output logic                                tx_valid_o,
  input  wire logic                           tx_ready_i,
  // Receive buffer fill
  input  wire logic [spi_cfg_pkg::DW-1:0]     rx_data_i,
  input  wire logic                           rx_valid_i,
  output logic                                rx_ready_o
);
  import spi_cfg_pkg::*;

  typedef enum logic [3:0] {
    D_IDLE = 4'b0001,
    D_WAIT = 4'b0010,
    D_HDR  = 4'b0100,
    D_DATA = 4'b1000
  } dev_st_e;

  typedef struct packed {
    logic [2:0]                 cs_s;
    logic [2:0]                 sck_s;
    logic [2:0]                 si_s;
    logic                       cs_f;
    logic                       sck_f;
    logic                       si_f;
    dev_st_e                    st;
    logic [2:0]                 bit_n;
    logic [DW-1:0]              sh_in;
    logic [DW-1:0]              sh_out;
    logic                       rw;
    logic                       burst;
    logic                       single;
    logic [AW-1:0]              addr;
    logic                       so;
    logic [CFG_NUM-1:0][DW-1:0] cfg;
    logic                       cfg_wr;
    logic [AW-1:0]              cfg_addr;
    logic [DW-1:0]              cfg_data;
    logic                       strobe;
    logic [AW-1:0]              strobe_addr;
    logic                       tx_push;
    logic [DW-1:0]              tx_byte;
    logic                       rx_pop;
  } dev_s;

  dev_s              q;
  dev_s              d;
  logic [BUF_CW-1:0] tx_cnt;
  logic [BUF_CW-1:0] tx_free;
  logic [BUF_CW-1:0] rx_cnt;
  logic [DW-1:0]     rx_head;
  logic              rx_avail;

  assign tx_free = BUF_CW'(BUF_DEPTH) - tx_cnt;

  function automatic logic is_stat(input logic [AW-1:0] a);
    return (a >= STAT_FIRST) && (a <= STAT_LAST);
  endfunction

  function automatic logic [3:0] sat4(input logic [BUF_CW-1:0] c);
    return (c > BUF_CW'(AVAIL_MAX)) ? AVAIL_MAX : c[3:0];
  endfunction

  // Readable bytes for reads, free bytes for writes
  function automatic logic [3:0] avail4(input logic rd);
    return rd ? sat4(rx_cnt) : sat4(tx_free);
  endfunction

  function automatic logic [DW-1:0] stat_byte(input logic rd);
    return {1'b0, main_state_i, avail4(rd)};
  endfunction

  function automatic logic [DW-1:0] rd_val(input logic [AW-1:0] a);
    if (a == BUF_ADDR) begin
      return rx_avail ? rx_head : '0;
    end
    if (is_stat(a)) begin
      return {1'b0, rx_cnt};
    end
    if (a <= CFG_LAST) begin
      return q.cfg[a];
    end
    return '0;
  endfunction

  always_comb begin
    logic          cs_v;
    logic          sck_v;
    logic          si_v;
    logic          rise;
    logic          fall;
    logic          ld_rd;
    logic [DW-1:0] b;
    logic [AW-1:0] ra;
    logic [AW-1:0] na;
    d = q;
    d.cfg_wr = 1'b0;
    d.strobe = 1'b0;
    d.tx_push = 1'b0;
    d.rx_pop = 1'b0;
    d.cs_s = {q.cs_s[1:0], link.cs_n};
    d.sck_s = {q.sck_s[1:0], link.sclk};
    d.si_s = {q.si_s[1:0], link.mosi};
    cs_v = (q.cs_s[2] == q.cs_s[1]) ? q.cs_s[2] : q.cs_f;
    sck_v = (q.sck_s[2] == q.sck_s[1]) ? q.sck_s[2] : q.sck_f;
    si_v = (q.si_s[2] == q.si_s[1]) ? q.si_s[2] : q.si_f;
    d.cs_f = cs_v;
    d.sck_f = sck_v;
    d.si_f = si_v;
    rise = sck_v & ~q.sck_f;
    fall = ~sck_v & q.sck_f;
    b = {q.sh_in[DW-2:0], si_v};
    ld_rd = 1'b0;
    ra = q.addr;
    na = q.addr;
    case (q.st)
      D_IDLE: begin
        if (!cs_v) begin
          d.st = D_WAIT;
        end
      end
      D_WAIT: begin
        // Ready flag is the first status bit, low
        if (xosc_run_i) begin
          d.sh_out = stat_byte(1'b0);
          d.so = 1'b0;
          d.bit_n = 3'h0;
          d.st = D_HDR;
        end
      end
      D_HDR, D_DATA: begin
        if (fall) begin
          d.so = q.sh_out[3'h7 - q.bit_n];
        end
        if (rise) begin
          d.sh_in = b;
          d.bit_n = q.bit_n + 3'h1;
          // Direction now known: fix the count field
          if (q.st == D_HDR && q.bit_n == 3'h0) begin
            d.sh_out = {q.sh_out[DW-1:4], avail4(si_v)};
          end
        end
        if (rise && q.bit_n == 3'h7) begin
          if (q.st == D_HDR) begin
            d.rw = b[HDR_RW_BIT];
            d.burst = b[HDR_BURST_BIT];
            d.addr = b[AW-1:0];
            if (is_stat(b[AW-1:0]) && !b[HDR_BURST_BIT]) begin
              d.strobe = 1'b1;
              d.strobe_addr = b[AW-1:0];
              d.sh_out = stat_byte(b[HDR_RW_BIT]);
            end else begin
              d.st = D_DATA;
              d.single = is_stat(b[AW-1:0]);
              if (b[HDR_RW_BIT]) begin
                ld_rd = 1'b1;
                ra = b[AW-1:0];
              end else begin
                d.sh_out = stat_byte(1'b0);
              end
            end
          end else begin
            if (!q.rw) begin
              if (q.addr == BUF_ADDR) begin
                d.tx_push = 1'b1;
                d.tx_byte = b;
              end else if (q.addr <= CFG_LAST) begin
                d.cfg[q.addr] = b;
                d.cfg_wr = 1'b1;
                d.cfg_addr = q.addr;
                d.cfg_data = b;
              end
            end
            // Buffer address stays put during a burst
            na = (q.addr == BUF_ADDR) ? q.addr : q.addr + 6'h01;
            d.addr = na;
            if (!q.burst || q.single) begin
              d.st = D_HDR;
              d.sh_out = stat_byte(q.rw);
            end else if (q.rw) begin
              ld_rd = 1'b1;
              ra = na;
            end else begin
              d.sh_out = stat_byte(1'b0);
            end
          end
        end
      end
      default: begin
        d.st = D_IDLE;
      end
    endcase
    if (ld_rd) begin
      d.sh_out = rd_val(ra);
      d.rx_pop = (ra == BUF_ADDR) && rx_avail;
    end
    // Partial bytes are dropped, nothing is committed
    if (cs_v) begin
      d.st = D_IDLE;
      d.so = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.cs_s <= 3'h7;
      q.cs_f <= 1'b1;
      q.st <= D_IDLE;
      q.so <= 1'b1;
      q.cfg <= {CFG_NUM{CFG_RST}};
    end else begin
      q <= d;
    end
  end

  sync_fifo #(
    .W     (DW),
    .DEPTH (BUF_DEPTH)
  ) tx_buf (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (q.tx_push),
    .in_ready_o  (),
    .in_data_i   (q.tx_byte),
    .out_valid_o (tx_valid_o),
    .out_ready_i (tx_ready_i),
    .out_data_o  (tx_data_o),
    .count_o     (tx_cnt)
  );

  sync_fifo #(
    .W     (DW),
    .DEPTH (BUF_DEPTH)
  ) rx_buf (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (rx_valid_i),
    .in_ready_o  (rx_ready_o),
    .in_data_i   (rx_data_i),
    .out_valid_o (rx_avail),
    .out_ready_i (q.rx_pop),
    .out_data_o  (rx_head),
    .count_o     (rx_cnt)
  );

  assign link.miso     = q.so;
  assign cfg_wr_o      = q.cfg_wr;
  assign cfg_addr_o    = q.cfg_addr;
  assign cfg_data_o    = q.cfg_data;
  assign strobe_o      = q.strobe;
  assign strobe_addr_o = q.strobe_addr;
endmodule

// >>> rtl/radio_spi_host.sv
`timescale 1ns/10ps
module radio_spi_host (
  // Clock and reset
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_i,
  // Serial link
  spi_link_if.host                         link,
  // Register port
  input  wire logic [spi_cfg_pkg::RA_W-1:0] addr_i,
  input  wire logic [spi_cfg_pkg::RD_W-1:0] wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic [spi_cfg_pkg::RD_W-1:0]     rdata_o
);
  import spi_cfg_pkg::*;

  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_RDY  = 6'b000010,
    H_LOAD = 6'b000100,
    H_LO   = 6'b001000,
    H_HI   = 6'b010000,
    H_GAP  = 6'b100000
  } host_st_e;

  typedef struct packed {
    logic [2:0]     so_s;
    logic           so_f;
    host_st_e       st;
    logic [CNT_W-1:0] cnt;
    logic [2:0]     bit_n;
    logic [AW-1:0]  left;
    logic           first;
    logic [DW-1:0]  sh_out;
    logic [DW-1:0]  sh_in;
    logic           sclk;
    logic           cs_n;
    logic           mosi;
    logic [RD_W-1:0] rdata;
    logic           tx_pop;
    logic           rx_push;
    logic [DW-1:0]  rx_byte;
  } host_s;

  host_s            q;
  host_s            d;
  logic             txq_valid;
  logic [DW-1:0]    txq_data;
  logic [HQ_CW-1:0] txq_cnt;
  logic             rxq_ready;
  logic [DW-1:0]    rxq_data;
  logic [HQ_CW-1:0] rxq_cnt;

  always_comb begin
    logic            so_v;
    logic [DW-1:0]   byte_v;
    logic [RD_W-1:0] sv;
    d = q;
    d.tx_pop = 1'b0;
    d.rx_push = 1'b0;
    d.rdata = '0;
    d.so_s = {q.so_s[1:0], link.miso};
    so_v = (q.so_s[2] == q.so_s[1]) ? q.so_s[2] : q.so_f;
    d.so_f = so_v;
    byte_v = q.first ? q.sh_out : txq_data;
    sv = '0;
    sv[STAT_BUSY_BIT] = q.st != H_IDLE;
    sv[STAT_TXC_LSB +: HQ_CW] = txq_cnt;
    sv[STAT_RXC_LSB +: HQ_CW] = rxq_cnt;
    if (rd_i) begin
      case (addr_i)
        REG_STAT: d.rdata = sv;
        REG_RXD:  d.rdata = RD_W'(rxq_data);
        default:  d.rdata = '0;
      endcase
    end
    case (q.st)
      H_IDLE: begin
        // Software builds the header and gives the byte count
        if (wr_i && addr_i == REG_CMD) begin
          d.sh_out = wdata_i[CMD_HDR_LSB +: DW];
          d.left = wdata_i[CMD_LEN_LSB +: AW];
          d.first = 1'b1;
          d.cs_n = 1'b0;
          d.st = H_RDY;
        end
      end
      H_RDY: begin
        if (!so_v) begin
          d.st = H_LOAD;
        end
      end
      H_LOAD: begin
        // Stall with clock low until data and room exist
        if (!q.rx_push && rxq_ready && (q.first || txq_valid)) begin
          d.tx_pop = !q.first;
          d.sh_out = byte_v;
          d.mosi = byte_v[DW-1];
          d.bit_n = 3'h0;
          d.cnt = '0;
          d.st = H_LO;
        end
      end
      H_LO: begin
        if (q.cnt == SCLK_HALF_CYC - 4'h1) begin
          d.sclk = 1'b1;
          d.cnt = '0;
          d.st = H_HI;
        end else begin
          d.cnt = q.cnt + 4'h1;
        end
      end
      H_HI: begin
        if (q.cnt == SCLK_HALF_CYC - 4'h1) begin
          d.sclk = 1'b0;
          d.cnt = '0;
          d.sh_in = {q.sh_in[DW-2:0], so_v};
          if (q.bit_n == 3'h7) begin
            d.rx_push = 1'b1;
            d.rx_byte = {q.sh_in[DW-2:0], so_v};
            if (q.left == '0) begin
              d.cs_n = 1'b1;
              d.st = H_GAP;
            end else begin
              d.left = q.left - 6'h01;
              d.first = 1'b0;
              d.st = H_LOAD;
            end
          end else begin
            d.bit_n = q.bit_n + 3'h1;
            d.sh_out = {q.sh_out[DW-2:0], 1'b0};
            d.mosi = q.sh_out[DW-2];
            d.st = H_LO;
          end
        end else begin
          d.cnt = q.cnt + 4'h1;
        end
      end
      H_GAP: begin
        // Lets the device release its output before reuse
        if (q.cnt == CS_GAP_CYC - 4'h1) begin
          d.cnt = '0;
          d.st = H_IDLE;
        end else begin
          d.cnt = q.cnt + 4'h1;
        end
      end
      default: begin
        d.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.so_s <= 3'h7;
      q.so_f <= 1'b1;
      q.st <= H_IDLE;
      q.cs_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  sync_fifo #(
    .W     (DW),
    .DEPTH (HQ_DEPTH)
  ) tx_q (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (wr_i && addr_i == REG_TXD),
    .in_ready_o  (),
    .in_data_i   (wdata_i[DW-1:0]),
    .out_valid_o (txq_valid),
    .out_ready_i (q.tx_pop),
    .out_data_o  (txq_data),
    .count_o     (txq_cnt)
  );

  sync_fifo #(
    .W     (DW),
    .DEPTH (HQ_DEPTH)
  ) rx_q (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (q.rx_push),
    .in_ready_o  (rxq_ready),
    .in_data_i   (q.rx_byte),
    .out_valid_o (),
    .out_ready_i (rd_i && addr_i == REG_RXD),
    .out_data_o  (rxq_data),
    .count_o     (rxq_cnt)
  );

  assign link.cs_n = q.cs_n;
  assign link.sclk = q.sclk;
  assign link.mosi = q.mosi;
  assign rdata_o   = q.rdata;
endmodule

// >>> tb/spi_link_chk.sv
`timescale 1ns/10ps
module spi_link_chk (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // Link wires and crystal readiness
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic mosi,
  input  wire logic miso,
  input  wire logic xosc_run_i
);
  logic       rdy_q;
  logic [9:0] bits_q;

  // Readiness seen and clock rises counted within one frame
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdy_q  <= 1'b0;
      bits_q <= 10'h000;
    end else if (cs_n) begin
      rdy_q  <= 1'b0;
      bits_q <= 10'h000;
    end else begin
      if (!miso) rdy_q <= 1'b1;
      if ($rose(sclk)) bits_q <= bits_q + 10'h001;
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence cs_open_s;
    $fell(cs_n) && xosc_run_i;
  endsequence
  sequence ready_s;
    ##[1:8] !miso;
  endsequence

  awake_ready_a: assert property (cs_open_s |-> ready_s)
    else $error("serial output not low after select");
  asleep_hold_a: assert property (!cs_n && !xosc_run_i && !rdy_q |-> miso)
    else $error("serial output low before crystal runs");
  idle_high_a: assert property (cs_n [*6] |-> miso)
    else $error("serial output not high while deselected");
  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  select_hold_a: assert property ($fell(cs_n) |=> (!cs_n) [*8])
    else $error("select released too early");
  wait_ready_a: assert property ($rose(sclk) |-> rdy_q)
    else $error("clocking began before ready");
  first_bit_a: assert property ($rose(sclk) && bits_q == 10'h000 |-> !miso)
    else $error("status bit 7 not low");
  hi_phase_a: assert property ($rose(sclk) |=> sclk [*7])
    else $error("serial clock high phase short");
  lo_phase_a: assert property ($fell(sclk) |=> (!sclk) [*7])
    else $error("serial clock low phase short");
  mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("data in changed while clock high");
  byte_frame_a: assert property ($rose(cs_n) |->
    bits_q >= 10'h008 && bits_q[2:0] == 3'h0)
    else $error("frame not whole bytes");
endmodule

// >>> tb/radio_spi_config_port_bench.sv
`timescale 1ns/10ps
module radio_spi_config_port_bench;
  import spi_cfg_pkg::*;
  logic        ref_clk_i, rst_i, xosc_run_i, tx_ready_i, rx_valid_i;
  logic        wr_i, rd_i, cfg_wr_o, strobe_o, tx_valid_o, rx_ready_o;
  logic [2:0]  main_state_i;
  logic [3:0]  addr_i;
  logic [5:0]  cfg_addr_o, strobe_addr_o;
  logic [7:0]  rx_data_i, cfg_data_o, tx_data_o;
  logic [15:0] wdata_i, rdata_o;
  int          error_cnt, n_compared, cyc;
  logic [7:0]  txb[$], rxb[$], txo[$];
  logic [13:0] cfq[$];
  logic [5:0]  stq[$];

  spi_link_if link ();
  radio_spi_dev radio_spi_dev_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .link(link), .xosc_run_i(xosc_run_i), .main_state_i(main_state_i),
    .cfg_wr_o(cfg_wr_o), .cfg_addr_o(cfg_addr_o), .cfg_data_o(cfg_data_o),
    .strobe_o(strobe_o), .strobe_addr_o(strobe_addr_o),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
    .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o));
  radio_spi_host radio_spi_host_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .link(link), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o));
  spi_link_chk spi_link_chk_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .cs_n(link.cs_n), .sclk(link.sclk), .mosi(link.mosi),
    .miso(link.miso), .xosc_run_i(xosc_run_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // Record what the device hands to the radio core
  always @(negedge ref_clk_i) begin
    if (cfg_wr_o === 1'b1) cfq.push_back({cfg_addr_o, cfg_data_o});
    if (strobe_o === 1'b1) stq.push_back(strobe_addr_o);
    if (tx_valid_o === 1'b1 && tx_ready_i) txo.push_back(tx_data_o);
  end

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compared=%0d mismatches=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] stat(input logic [3:0] c);
    return {8'h00, 1'b0, main_state_i, c};
  endfunction

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic start(input logic [7:0] hdr, input logic [5:0] n);
    foreach (txb[i]) reg_wr(REG_TXD, {8'h00, txb[i]});
    reg_wr(REG_CMD, {2'b00, n, hdr});
    txb.delete();
  endtask

  // Drain the reply queue until the engine is idle and empty
  task automatic collect();
    logic [15:0] s, r;
    int k;
    rxb.delete();
    k = 0;
    do begin
      reg_rd(REG_STAT, s);
      if (s[4:0] != 5'h00) begin
        reg_rd(REG_RXD, r);
        rxb.push_back(r[7:0]);
      end
      k++;
    end while ((s[STAT_BUSY_BIT] || s[4:0] != 5'h00) && k < 5000);
    // A transfer that never finishes counts as a failure
    if (k >= 5000) begin
      error_cnt++;
      close_out();
    end
  endtask

  task automatic rx_push(input logic [7:0] b);
    @(posedge ref_clk_i);
    rx_valid_i <= 1'b1;
    rx_data_i <= b;
    do @(negedge ref_clk_i); while (rx_ready_o !== 1'b1);
    @(posedge ref_clk_i);
    rx_valid_i <= 1'b0;
  endtask

  task automatic t_ready();
    @(posedge ref_clk_i);
    main_state_i <= 3'h2;
    xosc_run_i <= 1'b0;
    start(8'h36, 6'h00);
    repeat (40) @(posedge ref_clk_i);
    #1 chk({14'h0000, link.miso, link.sclk}, 16'h0002);
    @(posedge ref_clk_i);
    xosc_run_i <= 1'b1;
    collect();
    chk(16'(rxb.size()), 16'h0001);
    chk({8'h00, rxb[0]}, stat(4'hF));
    chk(16'(stq.size()), 16'h0001);
    chk({10'h000, stq[0]}, 16'h0036);
    $display("t_ready done");
  endtask

  task automatic t_cfg();
    @(posedge ref_clk_i);
    main_state_i <= 3'h5;
    txb = '{8'h5A};
    start(8'h02, 6'h01);
    collect();
    txb = '{8'h11, 8'h22};
    start(8'h44, 6'h02);
    collect();
    chk(16'(cfq.size()), 16'h0003);
    chk({2'b00, cfq[0]}, 16'h025A);
    chk({2'b00, cfq[1]}, 16'h0411);
    chk({2'b00, cfq[2]}, 16'h0522);
    chk({8'h00, rxb[2]}, stat(4'hF));
    txb = '{8'h00};
    start(8'h82, 6'h01);
    collect();
    chk({8'h00, rxb[0]}, stat(4'h0));
    chk({8'h00, rxb[1]}, 16'h005A);
    txb = '{8'h00, 8'h00, 8'h00};
    start(8'hC3, 6'h03);
    collect();
    chk({8'h00, rxb[1]}, {8'h00, CFG_RST});
    chk({8'h00, rxb[2]}, 16'h0011);
    chk({8'h00, rxb[3]}, 16'h0022);
    $display("t_cfg done");
  endtask

  task automatic t_rx();
    logic [7:0] exp_b [3];
    exp_b = '{8'hA1, 8'hB2, 8'hC3};
    foreach (exp_b[i]) rx_push(exp_b[i]);
    txb = '{8'h00};
    start(8'hF0, 6'h01);
    collect();
    chk({8'h00, rxb[0]}, stat(4'h3));
    chk({8'h00, rxb[1]}, 16'h0003);
    txb = '{8'h00, 8'h00, 8'h00};
    start(8'hFF, 6'h03);
    collect();
    chk({8'h00, rxb[0]}, stat(4'h3));
    foreach (exp_b[i]) chk({8'h00, rxb[i+1]}, {8'h00, exp_b[i]});
    $display("t_rx done");
  endtask

  task automatic t_tx();
    logic [15:0] s;
    @(posedge ref_clk_i);
    tx_ready_i <= 1'b0;
    for (int i = 1; i <= 17; i++) reg_wr(REG_TXD, 16'(i));
    reg_rd(REG_STAT, s);
    chk({11'h000, s[9:5]}, 16'h0010);
    start(8'h7F, 6'h10);
    collect();
    chk(16'(rxb.size()), 16'h0011);
    chk(16'(txo.size()), 16'h0000);
    @(posedge ref_clk_i);
    tx_ready_i <= 1'b1;
    repeat (40) @(posedge ref_clk_i);
    chk(16'(txo.size()), 16'h0010);
    foreach (txo[i]) chk({8'h00, txo[i]}, 16'(i + 1));
    $display("t_tx done");
  endtask

  initial begin
    rst_i = 1'b1;
    xosc_run_i = 1'b1;
    main_state_i = 3'h0;
    tx_ready_i = 1'b1;
    rx_valid_i = 1'b0;
    rx_data_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 16'h0000;
    error_cnt = 0;
    n_compared = 0;
    cyc = 0;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    t_ready();
    t_cfg();
    t_rx();
    t_tx();
    close_out();
  end
endmodule
